// *** pkg/mac_cascade_consts.svh ***
// constants for the cascade accumulate output stage
// assumes inclusion by bare name from the package and the design file
// Functional notes
// - bypass high shortens cascade path latency
// - all delays zero: sum appears three clocks later
// - accept low registers cascade word into sum
// - accept high ignores cascade port entirely
// - continue low restarts the running sum
// - continue high accumulates, rounding ignored
// - swap high outputs upper accumulator word
// - both overlapping 16-bit halves readable
// - swap low toggles upper and lower words
// - swap low loads no new results
// - enable low drives output register contents
// - enable high floats all sum lines
// - data, cascade, upper word are two's complement
// - round adds one at weight 2^7
// - rounding only on first accumulation cycle
// - negate controls subtract their product
`ifndef MAC_CASCADE_CONSTS_SVH
`define MAC_CASCADE_CONSTS_SVH
`define ACC_W        24
`define WORD_W       16
`define PROD_W       24
`define CAS_LSB      8
`define ROUND_BIT    7
`define CAS_STAGES   3
`define OUT_HI_LSB   8
`define ROUND_ONE    24'h00_0080
`define CHECK_WARMUP 4'h8
`endif

// *** pkg/mac_cascade_pkg.sv ***
// types for the cascade accumulate output stage
// assumes the constants header is on the include path
`include "mac_cascade_consts.svh"
package mac_cascade_pkg;
    typedef logic signed [`ACC_W-1:0]  acc_t;
    typedef logic signed [`WORD_W-1:0] word_t;
    typedef enum logic [0:0] {
        SEL_UPPER = 1'b0,
        SEL_LOWER = 1'b1
    } word_sel_e;
endpackage

// *** hdl/mac_cascade_accumulate_output.sv ***
// accumulator, cascade input and swapped output word stage
// assumes products arrive already pipelined and aligned by the caller
`timescale 1ns/1ps
`include "mac_cascade_consts.svh"
module mac_cascade_accumulate_output (
    input  wire logic                     clk_in,
    input  wire logic                     rst_in,
    input  wire logic signed [`PROD_W-1:0] product_ab_in,
    input  wire logic signed [`PROD_W-1:0] product_cd_in,
    input  wire logic                     negate_first_product_in,
    input  wire logic                     negate_second_product_in,
    input  wire logic signed [`WORD_W-1:0] cascade_word_in,
    input  wire logic                     cascade_accept_n_in,
    input  wire logic                     cascade_bypass_in,
    input  wire logic                     sum_continue_in,
    input  wire logic                     round_request_in,
    input  wire logic                     word_swap_in,
    input  wire logic                     output_enable_n_in,
    output logic      [`WORD_W-1:0]        sum_out,
    output logic      [`WORD_W-1:0]        sum_oe_out
);
    ////////////////////////////////////////////////////////////////////////
    // input registers; no reset, contents undefined until flushed
    mac_cascade_pkg::acc_t  ab_q;
    mac_cascade_pkg::acc_t  cd_q;
    logic                   negate_first_product_q;
    logic                   negate_second_product_q;
    logic                   cont_q;
    logic                   rnd_q;
    logic                   swap_q;
    mac_cascade_pkg::acc_t  cas_pipe_q [`CAS_STAGES];
    mac_cascade_pkg::acc_t  acc_q;
    logic [`WORD_W-1:0]     upper_q;
    logic [`WORD_W-1:0]     lower_q;
    mac_cascade_pkg::word_sel_e sel_q;
    logic [`WORD_W-1:0]     out_q;

    // cascade word placed at bits 8..23, dropped when not accepted
    wire mac_cascade_pkg::acc_t cas_aligned = cascade_accept_n_in ? '0 :
        {cascade_word_in, {`CAS_LSB{1'b0}}};

    always_ff @(posedge clk_in) begin
        ab_q   <= product_ab_in;
        cd_q   <= product_cd_in;
        negate_first_product_q <= negate_first_product_in;
        negate_second_product_q <= negate_second_product_in;
        cont_q <= sum_continue_in;
        rnd_q  <= round_request_in;
        swap_q <= word_swap_in;
    end

    // cascade delay pipe; stage 0 takes the aligned word
    generate
        for (genvar i = 0; i < `CAS_STAGES; i++) begin : g_cas
            if (i == 0) begin : g_first
                always_ff @(posedge clk_in) begin
                    cas_pipe_q[i] <= cas_aligned;
                end
            end else begin : g_next
                always_ff @(posedge clk_in) begin
                    cas_pipe_q[i] <= cas_pipe_q[i-1];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // summation
    // bypass takes the cascade word from the first stage, else the last
    wire mac_cascade_pkg::acc_t cas_sel = cascade_bypass_in ? cas_pipe_q[0] :
        cas_pipe_q[`CAS_STAGES-1];
    wire mac_cascade_pkg::acc_t ab_term = negate_first_product_q ? -ab_q : ab_q;
    wire mac_cascade_pkg::acc_t cd_term = negate_second_product_q ? -cd_q : cd_q;
    // rounding only on the first cycle of a sequence
    wire mac_cascade_pkg::acc_t rnd_term = (rnd_q && !cont_q) ?
        mac_cascade_pkg::acc_t'(1 << `ROUND_BIT) : '0;
    wire mac_cascade_pkg::acc_t base = cont_q ? acc_q : '0;
    wire mac_cascade_pkg::acc_t acc_d = base + ab_term + cd_term + cas_sel + rnd_term;

    always_ff @(posedge clk_in) begin
        acc_q <= acc_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // double output register with toggle mode
    // in toggle mode the word shown next is the one not shown last
    function automatic logic [`WORD_W-1:0] toggle_word(
        input mac_cascade_pkg::word_sel_e last_sel,
        input logic [`WORD_W-1:0]         hi_word,
        input logic [`WORD_W-1:0]         lo_word
    );
        return (last_sel == mac_cascade_pkg::SEL_UPPER) ? lo_word : hi_word;
    endfunction

    wire mac_cascade_pkg::word_sel_e sel_flip = (sel_q == mac_cascade_pkg::SEL_UPPER) ?
        mac_cascade_pkg::SEL_LOWER : mac_cascade_pkg::SEL_UPPER;
    wire [`WORD_W-1:0] acc_upper = acc_q[`ACC_W-1:`OUT_HI_LSB];
    wire [`WORD_W-1:0] acc_lower = acc_q[`WORD_W-1:0];
    wire [`WORD_W-1:0] next_word = swap_q ? acc_upper :
        toggle_word(sel_q, upper_q, lower_q);

    always_ff @(posedge clk_in) begin
        if (swap_q) begin
            upper_q <= acc_upper;
            lower_q <= acc_lower;
            sel_q   <= mac_cascade_pkg::SEL_UPPER;
        end else begin
            sel_q <= sel_flip;
        end
        out_q <= next_word;
    end

    // enable is unclocked at the pin; the pad sees oe straight from the input
    always_comb begin
        sum_out    = out_q;
        sum_oe_out = {`WORD_W{!output_enable_n_in}};
    end

    ////////////////////////////////////////////////////////////////////////
    // check qualification: the datapath has no reset, so the checks wait
    // until the pipes have been flushed after a pulse on rst_in
    logic [3:0] warm_q;
    wire        checks_on = (warm_q == `CHECK_WARMUP);

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            warm_q <= 4'h0;
        end else if (!checks_on) begin
            warm_q <= warm_q + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_upper_last;
        !swap_q && sel_q == mac_cascade_pkg::SEL_UPPER;
    endsequence

    sequence s_lower_last;
        !swap_q && sel_q == mac_cascade_pkg::SEL_LOWER;
    endsequence

    sequence s_plain_start;
        !cont_q && !rnd_q;
    endsequence

    sequence s_rounded_start;
        !cont_q && rnd_q;
    endsequence

    property p_oe_float;
        @(posedge clk_in) disable iff (!checks_on)
        output_enable_n_in |-> sum_oe_out == '0;
    endproperty
    a_oe_follows_pin: assert property (p_oe_float)
        else $error("sum bus not floated");

    property p_oe_drive;
        @(posedge clk_in) disable iff (!checks_on)
        !output_enable_n_in |-> sum_oe_out == '1;
    endproperty
    a_oe_drives_bus: assert property (p_oe_drive)
        else $error("sum bus not driven");

    property p_swap_upper;
        @(posedge clk_in) disable iff (!checks_on)
        swap_q |=> sum_out == $past(acc_q[`ACC_W-1:`OUT_HI_LSB]);
    endproperty
    a_swap_upper_word: assert property (p_swap_upper)
        else $error("upper word not driven");

    property p_both_words;
        @(posedge clk_in) disable iff (!checks_on)
        swap_q |=> lower_q == $past(acc_q[`WORD_W-1:0]);
    endproperty
    a_lower_word_kept: assert property (p_both_words)
        else $error("lower word not captured");

    property p_hold_no_load;
        @(posedge clk_in) disable iff (!checks_on)
        !swap_q |=> upper_q == $past(upper_q) && lower_q == $past(lower_q);
    endproperty
    a_hold_no_load: assert property (p_hold_no_load)
        else $error("output loaded in toggle mode");

    property p_toggle_to_lower;
        @(posedge clk_in) disable iff (!checks_on)
        s_upper_last |=> sum_out == $past(lower_q);
    endproperty
    a_toggle_lower_word: assert property (p_toggle_to_lower)
        else $error("toggle did not show lower word");

    property p_toggle_to_upper;
        @(posedge clk_in) disable iff (!checks_on)
        s_lower_last |=> sum_out == $past(upper_q);
    endproperty
    a_toggle_upper_word: assert property (p_toggle_to_upper)
        else $error("toggle did not show upper word");

    property p_restart_sum;
        @(posedge clk_in) disable iff (!checks_on)
        s_plain_start |=> acc_q == $past(ab_term + cd_term + cas_sel);
    endproperty
    a_restart_sum: assert property (p_restart_sum)
        else $error("sum not restarted");

    property p_round_first;
        @(posedge clk_in) disable iff (!checks_on)
        s_rounded_start |=> acc_q == $past(ab_term + cd_term + cas_sel + `ROUND_ONE);
    endproperty
    a_round_first_cycle: assert property (p_round_first)
        else $error("rounded start wrong");

    property p_continue_adds;
        @(posedge clk_in) disable iff (!checks_on)
        cont_q |=> acc_q == $past(acc_q + ab_term + cd_term + cas_sel);
    endproperty
    a_continue_adds: assert property (p_continue_adds)
        else $error("accumulation wrong or rounded");

    property p_cascade_dropped;
        @(posedge clk_in) disable iff (!checks_on)
        cascade_accept_n_in |=> cas_pipe_q[0] == '0;
    endproperty
    a_cascade_ignored: assert property (p_cascade_dropped)
        else $error("cascade word used while refused");

    property p_cascade_taken;
        @(posedge clk_in) disable iff (!checks_on)
        !cascade_accept_n_in |=>
            cas_pipe_q[0] == {$past(cascade_word_in), {`CAS_LSB{1'b0}}};
    endproperty
    a_cascade_aligned: assert property (p_cascade_taken)
        else $error("cascade word not taken at bit 8");
endmodule

// *** tb/sum_bus_model.sv ***
// pulled-up system bus that the sum lines drive
// assumes one enable per line, high while the block drives it
`timescale 1ns/1ps
module sum_bus_model (
    input  wire logic [15:0] sum_in,
    input  wire logic [15:0] oe_in,
    output logic      [15:0] bus_out
);
    // a released line floats up to the pull-up level
    always_comb for (int i = 0; i < 16; i++) bus_out[i] = oe_in[i] ? sum_in[i] : 1'b1;
endmodule

// *** tb/mac_cascade_accumulate_output_tb.sv ***
// self-checking bench for the cascade accumulate output stage
// assumes the design and the bus model are compiled first
`timescale 1ns/1ps
module mac_cascade_accumulate_output_tb;
    logic        clk = 0, rst = 1, n1 = 0, n2 = 0, an = 1, byp = 0;
    logic        cont = 0, rnd = 0, sw = 1, oen = 0;
    logic [23:0] ab = 0, cd = 0;
    logic [15:0] cas = 0, s, oe, bus, v;
    int          miscompares = 0, cmp_count = 0;
    always #2.5 clk = ~clk;
    mac_cascade_accumulate_output dut (.clk_in(clk), .rst_in(rst),
        .product_ab_in(ab), .product_cd_in(cd), .negate_first_product_in(n1),
        .negate_second_product_in(n2), .cascade_word_in(cas), .cascade_accept_n_in(an),
        .cascade_bypass_in(byp), .sum_continue_in(cont), .round_request_in(rnd),
        .word_swap_in(sw), .output_enable_n_in(oen), .sum_out(s), .sum_oe_out(oe));
    sum_bus_model bus_m (.sum_in(s), .oe_in(oe), .bus_out(bus));
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // load operands, then let the pipe settle before looking
    // products arrive already delayed; delay selects live upstream
    task run(input logic [23:0] a, input logic [23:0] c, input logic [15:0] w,
             input logic [15:0] exp);
        @(negedge clk);
        ab = a;
        cd = c;
        cas = w;
        repeat (8) @(negedge clk);
        chk(s, exp);
    endtask
    task report_and_stop;
        if (miscompares == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_path;
        an = 0;
        run(24'h00_1200, 24'h00_0300, 16'h0002, 16'h0017);
        n1 = 1;
        run(24'h00_1200, 24'h00_0300, 16'h0002, 16'hfff3);
        n1 = 0;
        n2 = 1;
        run(24'h00_1200, 24'h00_0300, 16'h0002, 16'h0011);
        n2 = 0;
        byp = 1;
        run(24'h00_1200, 24'h00_0300, 16'h0002, 16'h0017);
        byp = 0;
        an = 1;
        run(24'h00_1200, 24'h00_0300, 16'h0002, 16'h0015);
    endtask
    task t_latency;
        an = 0;
        byp = 1;
        run(24'h00_1200, 24'h00_0300, 16'h0002, 16'h0017);
        cas = 16'h0004;
        repeat (3) @(negedge clk);
        chk(s, 16'h0019);
        byp = 0;
        cas = 16'h0002;
        repeat (3) @(negedge clk);
        chk(s, 16'h0019);
        repeat (2) @(negedge clk);
        chk(s, 16'h0017);
        an = 1;
    endtask
    task t_acc;
        rnd = 1;
        run(24'h00_0180, 24'h00_0000, 16'h0000, 16'h0002);
        ab = 24'h00_0100;
        cont = 1;
        repeat (4) @(negedge clk);
        v = s;
        @(negedge clk);
        chk(s, 16'(v + 16'h0001));
        v = s;
        @(negedge clk);
        chk(s, 16'(v + 16'h0001));
        cont = 0;
        rnd = 0;
        run(24'h00_0180, 24'h00_0000, 16'h0000, 16'h0001);
    endtask
    task t_swap;
        run(24'h12_3456, 24'h00_0000, 16'h0000, 16'h1234);
        sw = 0;
        repeat (2) @(negedge clk);
        v = s;
        @(negedge clk);
        chk(v ^ s, 16'h2662);
        chk((v == 16'h1234) ? s : v, 16'h3456);
        ab = 24'h00_0000;
        repeat (5) @(negedge clk);
        v = s;
        @(negedge clk);
        chk(v ^ s, 16'h2662);
        sw = 1;
        run(24'h00_0000, 24'h00_0000, 16'h0000, 16'h0000);
    endtask
    task t_oe;
        @(negedge clk);
        oen = 1;
        #1;
        chk(bus, 16'hffff);
        chk(oe, 16'h0000);
        @(negedge clk);
        oen = 0;
        #1;
        chk(bus, 16'h0000);
        chk(oe, 16'hffff);
    endtask
    initial begin
        repeat (3) @(negedge clk);
        rst = 0;
        t_path;
        t_latency;
        t_acc;
        t_swap;
        t_oe;
        report_and_stop;
    end
    initial begin
        #5000;
        miscompares++;
        report_and_stop;
    end
endmodule
